// File: rtl/timer2_pkg.sv
// Purpose: shared constants for the capture/reload/baud timer
// Assumes: 32-bit AXI4-Lite register words, byte offsets below
// Notes:   bit positions index the 8-bit control words
package timer2_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MODE   = 8'h04;
   localparam logic [7:0] OFS_EXTST  = 8'h08;
   localparam logic [7:0] OFS_COUNT  = 8'h0C;
   localparam logic [7:0] OFS_CAPT   = 8'h10;
   localparam logic [7:0] OFS_RELOAD = 8'h14;
   localparam logic [7:0] OFS_PORT   = 8'h18;
   // control word fields
   localparam int CTL_OVF    = 7;
   localparam int CTL_EXT    = 6;
   localparam int CTL_ARX    = 5;
   localparam int CTL_ATX    = 4;
   localparam int CTL_EXEN   = 3;
   localparam int CTL_RUN    = 2;
   localparam int CTL_CSEL   = 1;
   localparam int CTL_CAPSEL = 0;
   // mode word fields
   localparam int MOD_BRX  = 5;
   localparam int MOD_BTX  = 4;
   localparam int MOD_CKOE = 1;
   localparam int MOD_DOWN_COUNT_ENABLE = 0;
   // toggle enable of timer n sits at bit 2*n; port drive at 4+n
   localparam int TOG_STEP  = 2;
   localparam int PORT_DRV  = 4;
   // writable masks
   localparam logic [7:0] MODE_MASK  = 8'h33;
   localparam logic [7:0] EXTST_MASK = 8'h05;
   localparam logic [7:0] PORT_MASK  = 8'h33;
   // reset values and count constants
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
   localparam logic [15:0] COUNT_TOP = 16'hFFFF;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_CAPTURE,
      MODE_RELOAD_UP,
      MODE_UPDOWN,
      MODE_BAUD
   } mode_type;
endpackage

// File: rtl/pin_sync_if.sv
// Purpose: carries synchronised pin levels and falling edges
// Assumes: one producer, one consumer on the same clock
// Notes:   fall is a one-cycle pulse
interface pin_sync_if #(parameter int WIDTH = 2);
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] fall;
   modport producer (output level, output fall);
   modport consumer (input level, input fall);
endinterface

// File: rtl/pin_sync.sv
// Purpose: three-flop pin synchroniser with falling-edge detect
// Assumes: pins idle high
// Notes:   a change counts once stages two and three agree
module pin_sync
#(
   parameter int WIDTH = 2
)
(
   // clock and reset
   input wire logic             clk,
   input wire logic             rst_n,
   // raw pins
   input wire logic [WIDTH-1:0] pinIn,
   // synchronised view
   pin_sync_if.producer         sync
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] level_d;
   logic [WIDTH-1:0] fall_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage1_q <= '1;
         stage2_q <= '1;
         stage3_q <= '1;
      end else begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // accept a level only when stages agree
   assign level_d = (stage2_q & stage3_q) | (level_q & (stage2_q | stage3_q));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         level_q <= '1;
         fall_q  <= '0;
      end else begin
         level_q <= level_d;
         fall_q  <= level_q & ~level_d;
      end
   end

   assign sync.level = level_q;
   assign sync.fall  = fall_q;
endmodule

// File: rtl/timer2_capture_reload_baud.sv
// Purpose: 16-bit timer with capture, auto-reload and baud modes
// Assumes: prescaledTick and otherOverflow are pulses on clk
// Notes:   registers reached over AXI4-Lite, one word each
// Operation
// - 16-bit counter counts timer ticks or external events by select bit
// - overflow or underflow sets the overflow flag unless baud or clock-out selects are set
// - capture mode without trigger enable is a plain counter
// - trigger falling edge with enable copies count into capture register
// - qualifying trigger falling edge in capture mode sets external flag
// - external flag requests timer interrupt like overflow flag
// - capture select plus trigger enable captures on trigger falls
// - any baud select forces reload on overflow, ignoring capture select
// - auto-reload loads the reload register on overflow
// - auto-reload trigger fall with enable reloads and sets external flag
// - up-only counts to FFFF, flags overflow; either flag may interrupt
// - up/down mode counts up while trigger high, down while low
// - counting up overflows at FFFF, flags, reloads
// - counting down loads FFFF and flags when count equals reload
// - up/down mode toggles external flag on overflow and underflow
// - up/down mode external flag raises no interrupt
// - baud mode counts the prescaled timer clock
// - per-UART clock selects pick counter overflow as baud source
// - transmit and receive baud sources chosen independently
// - other timers get toggle outputs on their count pins
// - toggle enable picks port data or overflow toggle for the pin
// - overflow flag not set while baud or clock-out selects are set
module timer2_capture_reload_baud
   import timer2_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // pins
   input  wire logic              triggerPin,
   input  wire logic              eventPin,
   output logic [1:0]             countPinOut,
   output logic [1:0]             countPinOe,
   // timer clock and other timers
   input  wire logic              prescaledTick,
   input  wire logic [1:0]        otherOverflow,
   // uart baud clocks
   output logic                   uartATxClk,
   output logic                   uartARxClk,
   output logic                   uartBTxClk,
   output logic                   uartBRxClk,
   // interrupt request
   output logic                   timerEventReq
);
   pin_sync_if #(.WIDTH(2)) pinBus ();

   logic              trigLevel;
   logic              trigFall;
   logic              eventFall;

   logic [7:0]        ctrl_q;
   logic [7:0]        mode_q;
   logic [7:0]        extSt_q;
   logic [7:0]        port_q;
   logic [15:0]       count_q;
   logic [15:0]       count_d;
   logic [15:0]       capt_q;
   logic [15:0]       reload_q;

   logic              awHeld_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic              wHeld_q;
   logic [31:0]       wData_q;
   logic [3:0]        wStrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic              doWrite;
   logic [31:0]       readWord;

   mode_type          mode;
   logic              baudSel;
   logic              tick;
   logic              hwOvf;
   logic              extEvt;
   logic              extTgl;
   logic              capNow;
   logic              ovfSet;

   logic [1:0]        toggle_q;
   logic [1:0]        pinOut_q;
   logic [1:0]        pinOe_q;
   logic              aTx_q;
   logic              aRx_q;
   logic              bTx_q;
   logic              bRx_q;
   logic              req_q;

   // pin synchroniser
   pin_sync #(.WIDTH(2)) uSync (
      .clk   (clk),
      .rst_n (rst_n),
      .pinIn ({eventPin, triggerPin}),
      .sync  (pinBus.producer)
   );

   assign trigLevel = pinBus.level[0];
   assign trigFall  = pinBus.fall[0];
   assign eventFall = pinBus.fall[1];

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      isMapped = (a == ADDR_W'(OFS_CTRL))  || (a == ADDR_W'(OFS_MODE))
              || (a == ADDR_W'(OFS_EXTST)) || (a == ADDR_W'(OFS_COUNT))
              || (a == ADDR_W'(OFS_CAPT))  || (a == ADDR_W'(OFS_RELOAD))
              || (a == ADDR_W'(OFS_PORT));
   endfunction

   // write channels
   assign s_axi_awready = !awHeld_q && !bvalid_q;
   assign s_axi_wready  = !wHeld_q && !bvalid_q;
   assign doWrite       = awHeld_q && wHeld_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
         wHeld_q  <= 1'b0;
         wData_q  <= RST_RDATA;
         wStrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read channel
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_comb begin
      readWord = RST_RDATA;
      if (s_axi_araddr == ADDR_W'(OFS_CTRL)) begin
         readWord[7:0] = ctrl_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_MODE)) begin
         readWord[7:0] = mode_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_EXTST)) begin
         readWord[7:0] = extSt_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_COUNT)) begin
         readWord[15:0] = count_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_CAPT)) begin
         readWord[15:0] = capt_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_RELOAD)) begin
         readWord[15:0] = reload_q;
      end else if (s_axi_araddr == ADDR_W'(OFS_PORT)) begin
         readWord[7:0] = port_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= RST_RDATA;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= readWord;
         rresp_q  <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // mode decode
   assign baudSel = ctrl_q[CTL_ARX] | ctrl_q[CTL_ATX]
                  | mode_q[MOD_BRX] | mode_q[MOD_BTX];

   always_comb begin
      if (baudSel) begin
         mode = MODE_BAUD;
      end else if (ctrl_q[CTL_CAPSEL]) begin
         mode = MODE_CAPTURE;
      end else if (mode_q[MOD_DOWN_COUNT_ENABLE]) begin
         mode = MODE_UPDOWN;
      end else begin
         mode = MODE_RELOAD_UP;
      end
   end

   // count source and run gate
   assign tick = ctrl_q[CTL_RUN]
      && ((baudSel || !ctrl_q[CTL_CSEL]) ? prescaledTick
                                         : eventFall);

   // counter next state
   always_comb begin
      count_d = count_q;
      hwOvf   = 1'b0;
      extEvt  = 1'b0;
      extTgl  = 1'b0;
      capNow  = 1'b0;
      unique case (mode)
         MODE_CAPTURE: begin
            if (tick) begin
               count_d = count_q + COUNT_ONE;
               hwOvf   = (count_q == COUNT_TOP);
            end
            if (ctrl_q[CTL_EXEN] && trigFall) begin
               capNow = 1'b1;
               extEvt = 1'b1;
            end
         end
         MODE_RELOAD_UP, MODE_BAUD: begin
            if (tick) begin
               if (count_q == COUNT_TOP) begin
                  count_d = reload_q;
                  hwOvf   = 1'b1;
               end else begin
                  count_d = count_q + COUNT_ONE;
               end
            end
            if (ctrl_q[CTL_EXEN] && trigFall) begin
               extEvt = 1'b1;
               if (mode == MODE_RELOAD_UP) begin
                  count_d = reload_q;
               end
            end
         end
         MODE_UPDOWN: begin
            if (tick) begin
               if (trigLevel) begin
                  if (count_q == COUNT_TOP) begin
                     count_d = reload_q;
                     hwOvf   = 1'b1;
                     extTgl  = 1'b1;
                  end else begin
                     count_d = count_q + COUNT_ONE;
                  end
               end else if (count_q == reload_q) begin
                  count_d = COUNT_TOP;
                  hwOvf   = 1'b1;
                  extTgl  = 1'b1;
               end else begin
                  count_d = count_q - COUNT_ONE;
               end
            end
         end
      endcase
   end

   assign ovfSet = hwOvf && !(baudSel || mode_q[MOD_CKOE]);

   // control word, hardware set wins over software clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= RST_BYTE;
      end else begin
         if (doWrite && awAddr_q == ADDR_W'(OFS_CTRL) && wStrb_q[0]) begin
            ctrl_q <= wData_q[7:0];
         end
         if (ovfSet) begin
            ctrl_q[CTL_OVF] <= 1'b1;
         end
         if (extEvt) begin
            ctrl_q[CTL_EXT] <= 1'b1;
         end else if (extTgl) begin
            ctrl_q[CTL_EXT] <= ~ctrl_q[CTL_EXT];
         end
      end
   end

   // configuration words
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_q   <= RST_BYTE;
         extSt_q  <= RST_BYTE;
         port_q   <= RST_BYTE;
         reload_q <= RST_WORD;
      end else if (doWrite) begin
         if (awAddr_q == ADDR_W'(OFS_MODE) && wStrb_q[0]) begin
            mode_q <= wData_q[7:0] & MODE_MASK;
         end
         if (awAddr_q == ADDR_W'(OFS_EXTST) && wStrb_q[0]) begin
            extSt_q <= wData_q[7:0] & EXTST_MASK;
         end
         if (awAddr_q == ADDR_W'(OFS_PORT) && wStrb_q[0]) begin
            port_q <= wData_q[7:0] & PORT_MASK;
         end
         if (awAddr_q == ADDR_W'(OFS_RELOAD)) begin
            if (wStrb_q[0]) begin
               reload_q[7:0] <= wData_q[7:0];
            end
            if (wStrb_q[1]) begin
               reload_q[15:8] <= wData_q[15:8];
            end
         end
      end
   end

   // counter, software write wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_q <= RST_WORD;
      end else if (doWrite && awAddr_q == ADDR_W'(OFS_COUNT)) begin
         if (wStrb_q[0]) begin
            count_q[7:0] <= wData_q[7:0];
         end
         if (wStrb_q[1]) begin
            count_q[15:8] <= wData_q[15:8];
         end
      end else begin
         count_q <= count_d;
      end
   end

   // capture word, capture wins over software write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         capt_q <= RST_WORD;
      end else if (capNow) begin
         capt_q <= count_q;
      end else if (doWrite && awAddr_q == ADDR_W'(OFS_CAPT)) begin
         if (wStrb_q[0]) begin
            capt_q[7:0] <= wData_q[7:0];
         end
         if (wStrb_q[1]) begin
            capt_q[15:8] <= wData_q[15:8];
         end
      end
   end

   // baud clocks, each source picked on its own
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aTx_q <= 1'b0;
         aRx_q <= 1'b0;
         bTx_q <= 1'b0;
         bRx_q <= 1'b0;
      end else begin
         aTx_q <= ctrl_q[CTL_ATX] ? hwOvf : otherOverflow[1];
         aRx_q <= ctrl_q[CTL_ARX] ? hwOvf : otherOverflow[1];
         bTx_q <= mode_q[MOD_BTX] ? hwOvf : otherOverflow[1];
         bRx_q <= mode_q[MOD_BRX] ? hwOvf : otherOverflow[1];
      end
   end

   assign uartATxClk = aTx_q;
   assign uartARxClk = aRx_q;
   assign uartBTxClk = bTx_q;
   assign uartBRxClk = bRx_q;

   // interrupt request from flags
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_q <= 1'b0;
      end else begin
         req_q <= ctrl_q[CTL_OVF]
            | (ctrl_q[CTL_EXT] & (mode != MODE_UPDOWN));
      end
   end

   assign timerEventReq = req_q;

   // overflow toggle outputs of the other timers
   for (genvar i = 0; i < 2; i++) begin : g_tog
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            toggle_q[i] <= 1'b0;
            pinOut_q[i] <= 1'b0;
            pinOe_q[i]  <= 1'b0;
         end else begin
            toggle_q[i] <= toggle_q[i] ^ otherOverflow[i];
            pinOut_q[i] <= extSt_q[TOG_STEP*i] ? toggle_q[i]
                                               : port_q[i];
            pinOe_q[i]  <= extSt_q[TOG_STEP*i] | port_q[PORT_DRV+i];
         end
      end
   end

   assign countPinOut = pinOut_q;
   assign countPinOe  = pinOe_q;
endmodule

// File: dv/timer_far_side.sv
// Purpose: far-side model: trigger, event and tick sources
// Assumes: pins idle high, commands come from the bench
// Notes:   pin levels follow the commands one edge later
module timer_far_side
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // commanded pin levels
   input  wire logic       trigCmd,
   input  wire logic       evCmd,
   // pins and ticks
   output logic            triggerPin    = 1'b1,
   output logic            eventPin      = 1'b1,
   output logic            prescaledTick = 1'b0,
   output logic [1:0]      otherOverflow = 2'b00
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   always_ff @(posedge clk) begin
      triggerPin <= trigCmd;
      eventPin <= evCmd;
      cnt <= rst_n ? cnt + 1 : 0;
      prescaledTick <= (cnt % 4) == 3;
      otherOverflow <= {(cnt % 11) == 5, (cnt % 7) == 3};
   end
endmodule

// File: dv/timer2_chk.sv
// Purpose: port checks of the capture/reload/baud timer
// Assumes: bench offers write address and data together
// Notes:   shadow selects follow taken control writes
module timer2_chk
   import timer2_pkg::*;
(
   // clock and reset
   input logic        clk,
   input logic        rst_n,
   // register bus
   input logic [7:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   // timer side
   input logic [1:0]  otherOverflow,
   input logic        uartATxClk,
   input logic        uartBRxClk,
   input logic        timerEventReq,
   input logic [1:0]  countPinOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl_q;
   logic [7:0] mod_q;
   logic       wrGo;
   assign wrGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl_q <= RST_BYTE;
         mod_q <= RST_BYTE;
      end else if (wrGo && s_axi_awaddr == OFS_CTRL) begin
         ctl_q <= s_axi_wdata[7:0];
      end else if (wrGo && s_axi_awaddr == OFS_MODE) begin
         mod_q <= s_axi_wdata[7:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_bHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bHold: assert property (p_bHold) else $error("write answer dropped");
   property p_rHold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rHold: assert property (p_rHold) else $error("read answer dropped");
   property p_wLat;
      wrGo |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wLat: assert property (p_wLat) else $error("write answer late");
   property p_rLat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rLat: assert property (p_rLat) else $error("read answer late");
   property p_wBlk;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wBlk: assert property (p_wBlk) else $error("write taken while busy");
   property p_rBlk;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_rBlk: assert property (p_rBlk) else $error("read taken while busy");
   property p_rstOut;
      $rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !timerEventReq
                       && countPinOe == 2'b00;
   endproperty
   a_rstOut: assert property (p_rstOut) else $error("output not cleared");
   property p_baudA;
      uartATxClk && !ctl_q[CTL_ATX] && !$past(ctl_q[CTL_ATX])
      && !$past(ctl_q[CTL_ATX], 2) |-> $past(otherOverflow[1]);
   endproperty
   a_baudA: assert property (p_baudA) else $error("uart a tick source");
   property p_baudB;
      uartBRxClk && !mod_q[MOD_BRX] && !$past(mod_q[MOD_BRX])
      && !$past(mod_q[MOD_BRX], 2) |-> $past(otherOverflow[1]);
   endproperty
   a_baudB: assert property (p_baudB) else $error("uart b tick source");
   property p_pulse;
      uartATxClk |=> !uartATxClk;
   endproperty
   a_pulse: assert property (p_pulse) else $error("baud tick too long");
   c_write: cover property (wrGo);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   c_req: cover property ($rose(timerEventReq));
endmodule

bind timer2_capture_reload_baud timer2_chk timer2_chk_inst (.*);

// File: dv/tb_top.sv
// Purpose: self-checking bench of the capture/reload/baud timer
// Assumes: far-side model drives pins and ticks
// Notes:   expected values come from an integer model
module tb_top
   import timer2_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_n = 1'b0, trigCmd = 1'b1, evCmd = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, prev;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, triggerPin, eventPin, prescaledTick;
   logic [1:0]  s_axi_bresp, s_axi_rresp, otherOverflow;
   logic [1:0]  countPinOut, countPinOe;
   logic        uartATxClk, uartARxClk, uartBTxClk, uartBRxClk;
   logic        timerEventReq;
   int          mismatches = 0, comparisons = 0, seed, i, n;
   int          mc, me, rl, tk, ua, ub, o1, tg;

   always #2.5 clk = ~clk;

   timer_far_side timer_far_side_inst (.*);
   timer2_capture_reload_baud timer2_capture_reload_baud_inst (.*);

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY);
      int k;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 64; k++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 64) begin
         mismatches++;
         finish_test();
      end
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY);
      int k;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 64; k++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 64) begin
         mismatches++;
         finish_test();
      end
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   // model step of the 16-bit count, ext flag toggle on wrap
   function automatic void step(input bit up);
      if (up) begin
         me ^= int'(mc == 65535);
         mc = (mc == 65535) ? rl : mc + 1;
      end else begin
         me ^= int'(mc == rl);
         mc = (mc == rl) ? 65535 : mc - 1;
      end
   endfunction

   task automatic walk(input bit up, input int cnt);
      trigCmd <= up;
      repeat (8) @(posedge clk);
      repeat (cnt) begin
         evCmd <= 1'b0;
         repeat (6) @(posedge clk);
         evCmd <= 1'b1;
         repeat (6) @(posedge clk);
         step(up);
      end
   endtask

   task automatic fall;
      trigCmd <= 1'b0;
      repeat (8) @(posedge clk);
      trigCmd <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   initial begin
      seed = 15960;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 8; i++)
         rd(8'(i * 4), 32'h0, (i == 7) ? RESP_SLVERR : RESP_OKAY);
      r = $random(seed);
      wr(8'h1C, r, RESP_SLVERR);
      wr(OFS_MODE, r);
      rd(OFS_MODE, r & 32'(MODE_MASK));
      wr(OFS_MODE, 32'h0);
      $display("test registers done");
      n = 3 + ($random(seed) & 3);
      rl = 0;
      mc = 65533;
      wr(OFS_COUNT, 32'(mc));
      wr(OFS_CTRL, 32'h7);
      walk(1'b1, n);
      rd(OFS_COUNT, 32'(mc));
      rd(OFS_CTRL, 32'h87);
      chk(32'(timerEventReq), 32'h1);
      wr(OFS_CTRL, 32'h3);
      walk(1'b1, 2);
      rd(OFS_COUNT, 32'(mc - 2));
      $display("test counter done");
      mc = 4660;
      wr(OFS_COUNT, 32'(mc));
      wr(OFS_CTRL, 32'hF);
      walk(1'b1, 3);
      fall();
      rd(OFS_CAPT, 32'(mc));
      rd(OFS_CTRL, 32'h4F);
      chk(32'(timerEventReq), 32'h1);
      $display("test capture done");
      rl = 43981;
      mc = 65534;
      wr(OFS_CTRL, 32'h0);
      wr(OFS_RELOAD, 32'(rl));
      wr(OFS_COUNT, 32'(mc));
      wr(OFS_CTRL, 32'h6);
      walk(1'b1, 3);
      rd(OFS_COUNT, 32'(mc));
      rd(OFS_CTRL, 32'h86);
      wr(OFS_CTRL, 32'hE);
      fall();
      rd(OFS_COUNT, 32'(rl));
      rd(OFS_CTRL, 32'h4E);
      chk(32'(timerEventReq), 32'h1);
      $display("test reload done");
      rl = 16;
      mc = 18;
      me = 0;
      wr(OFS_CTRL, 32'h0);
      wr(OFS_MODE, 32'h1);
      wr(OFS_RELOAD, 32'(rl));
      wr(OFS_COUNT, 32'(mc));
      wr(OFS_CTRL, 32'h6);
      walk(1'b0, 3);
      rd(OFS_COUNT, 32'(mc));
      rd(OFS_CTRL, 32'(6 + 128 + 64 * me));
      wr(OFS_CTRL, 32'h46);
      repeat (4) @(posedge clk);
      chk(32'(timerEventReq), 32'h0);
      walk(1'b1, 1);
      rd(OFS_COUNT, 32'(mc));
      rd(OFS_CTRL, 32'(6 + 128 + 64 * me));
      $display("test up-down done");
      wr(OFS_CTRL, 32'h0);
      wr(OFS_MODE, 32'h0);
      wr(OFS_RELOAD, 32'hFFFE);
      wr(OFS_COUNT, 32'hFFFE);
      wr(OFS_EXTST, 32'h4);
      wr(OFS_PORT, 32'h11);
      wr(OFS_CTRL, 32'h15);
      tk = 0;
      ua = 0;
      ub = 0;
      o1 = 0;
      tg = 0;
      prev = countPinOut[1];
      repeat (400) begin
         @(posedge clk);
         tk += int'(prescaledTick);
         ua += int'(uartATxClk);
         ub += int'(uartBRxClk);
         o1 += int'(otherOverflow[1]);
         tg += int'(countPinOut[1] != prev);
         prev = countPinOut[1];
      end
      chk(32'(ua * 2 >= tk - 2 && ua * 2 <= tk + 2), 32'h1);
      chk(32'(ub >= o1 - 1 && ub <= o1 + 1), 32'h1);
      chk(32'(tg >= o1 - 1 && tg <= o1 + 1), 32'h1);
      chk(32'(countPinOe), 32'h3);
      chk(32'(countPinOut[0]), 32'h1);
      rd(OFS_CTRL, 32'h15);
      $display("test baud done");
      finish_test();
   end
endmodule
